// ==== common/fmc_pkg.sv ====
`default_nettype none
package fmc_pkg;

    localparam logic [7:0] FLASH_CONFIG_OFFSET    = 8'h02;
    localparam logic [7:0] DC_LIGHT_CONFIG_OFFSET = 8'h01;

    localparam int VOLTAGE_FORCE_BIT = 7;
    localparam int MODE_HI           = 6;
    localparam int MODE_LO           = 5;
    localparam int OUTER_HI          = 4;
    localparam int OUTER_LO          = 3;
    localparam int CENTRE_HI         = 2;
    localparam int CENTRE_LO         = 0;

    localparam logic       VOLTAGE_FORCE_RESET = 1'b0;
    localparam logic [1:0] MODE_RESET          = 2'h0;
    localparam logic [1:0] OUTER_RESET         = 2'h0;
    localparam logic [2:0] CENTRE_RESET        = 3'h3;
    localparam logic [7:0] FLASH_CONFIG_RESET  = {VOLTAGE_FORCE_RESET, MODE_RESET,
                                                  OUTER_RESET, CENTRE_RESET};

    localparam logic [1:0] MODE_SHUTDOWN   = 2'h0;
    localparam logic [1:0] MODE_DC_LIGHT   = 2'h1;
    localparam logic [1:0] MODE_DC_FLASH   = 2'h2;
    localparam logic [1:0] MODE_VOLTAGE    = 2'h3;

    localparam longint CLK_HZ            = 25000000;
    localparam longint REFRESH_TIMEOUT_MS = 11200;
    localparam longint REFRESH_TIMEOUT_CYCLES = REFRESH_TIMEOUT_MS * CLK_HZ / 1000;

    // Currents in mA, indexed by code; low column then high-current column
    localparam logic [15:0] OUTER_MA_LO [4]  = '{16'h0113, 16'h014f, 16'h0181, 16'h01bd};
    localparam logic [15:0] OUTER_MA_HI [4]  = '{16'h0299, 16'h0307, 16'h037a, 16'h0401};
    localparam logic [15:0] CENTRE_MA_LO [8] = '{16'h0131, 16'h014f, 16'h0181, 16'h01f4,
                                                 16'h0262, 16'h0299, 16'h0307, 16'h0375};
    localparam logic [15:0] CENTRE_MA_HI [8] = '{16'h02d0, 16'h0307, 16'h0393, 16'h048d,
                                                 16'h05aa, 16'h060e, 16'h06ef, 16'h0802};

    typedef enum logic [3:0] {
        FMC_OP_SHUTDOWN = 4'h1,
        FMC_OP_DC_LIGHT = 4'h2,
        FMC_OP_DC_FLASH = 4'h4,
        FMC_OP_VOLTAGE  = 4'h8
    } fmc_op_t;

endpackage
`default_nettype wire

// ==== src/fmc_current_lut.sv ====
`timescale 1ns/1ps
`default_nettype none
module fmc_current_lut (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        enable,
    input  wire logic        high_current_select,
    input  wire logic [1:0]  outer_code,
    input  wire logic [2:0]  centre_code,
    output logic      [15:0] outer_ma,
    output logic      [15:0] centre_ma
);
    typedef struct packed {
        logic [15:0] outer;
        logic [15:0] centre;
    } fmc_lut_state_t;

    fmc_lut_state_t state_reg;
    fmc_lut_state_t state_next;

    always_comb begin
        state_next = '0;
        if (enable) begin
            state_next.outer  = high_current_select ? fmc_pkg::OUTER_MA_HI[outer_code]
                                                    : fmc_pkg::OUTER_MA_LO[outer_code];
            state_next.centre = high_current_select ? fmc_pkg::CENTRE_MA_HI[centre_code]
                                                    : fmc_pkg::CENTRE_MA_LO[centre_code];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign outer_ma  = state_reg.outer;
    assign centre_ma = state_reg.centre;
endmodule // fmc_current_lut
`default_nettype wire

// ==== src/fmc_flash_config.sv ====
// Functional notes
// - Writing one to the voltage-mode force bit forces constant-voltage operation; zero restores normal.
// - Reading the force bit returns the level of the voltage-mode input pin, not the stored value.
// - Mode 00 is shutdown, 01 DC light, 10 DC light plus flash, 11 constant voltage.
// - The host rewrites the mode within 11.2 s, otherwise the device shuts down on the safety timeout.
// - A write to the mode bits also copies them into the mode bits of the DC-light register.
// - The outer code selects 275/335/385/445 mA, or 665/775/890/1025 mA with high current.
// - The centre code selects 305..885 mA, or 720..2050 mA with high current, per code.
// - Reset loads force 0, mode 00, outer 00, centre 011, so the register reads 0x03.
`timescale 1ns/1ps
`default_nettype none
module fmc_flash_config #(
    parameter longint TIMEOUT_CYCLES = fmc_pkg::REFRESH_TIMEOUT_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        voltage_mode_pin,
    input  wire logic        high_current_select,
    output logic      [7:0]  flash_config_rdata,
    output logic             dc_light_mode_write,
    output logic      [1:0]  dc_light_mode_value,
    output logic      [3:0]  op_mode,
    output logic             voltage_source_active,
    output logic             timeout_shutdown,
    output logic      [15:0] outer_led_ma,
    output logic      [15:0] centre_led_ma
);
    typedef struct packed {
        logic                voltage_mode_force;
        logic [1:0]          mode;
        logic [1:0]          outer_led_flash_level;
        logic [2:0]          centre_led_flash_level;
        logic [7:0]          rdata;
        logic                mirror_write;
        logic [1:0]          mirror_value;
        fmc_pkg::fmc_op_t    op;
        logic                vsrc;
        logic                timed_out;
        logic [31:0]         refresh_count;
    } fmc_state_t;

    fmc_state_t state_reg;
    fmc_state_t state_next;
    logic       hit;
    logic       flash_ok;

    assign hit = reg_write && (reg_addr == fmc_pkg::FLASH_CONFIG_OFFSET);

    always_comb begin
        state_next = state_reg;
        state_next.mirror_write = 1'b0;
        if (hit) begin
            state_next.voltage_mode_force     = reg_wdata[fmc_pkg::VOLTAGE_FORCE_BIT];
            state_next.mode                   = reg_wdata[fmc_pkg::MODE_HI:fmc_pkg::MODE_LO];
            state_next.outer_led_flash_level  = reg_wdata[fmc_pkg::OUTER_HI:fmc_pkg::OUTER_LO];
            state_next.centre_led_flash_level =
                reg_wdata[fmc_pkg::CENTRE_HI:fmc_pkg::CENTRE_LO];
            state_next.mirror_write  = 1'b1;
            state_next.mirror_value  = reg_wdata[fmc_pkg::MODE_HI:fmc_pkg::MODE_LO];
            state_next.refresh_count = '0;
            state_next.timed_out     = 1'b0;
        end else if (state_reg.mode != fmc_pkg::MODE_SHUTDOWN) begin
            if (state_reg.refresh_count >= 32'(TIMEOUT_CYCLES - 1)) begin
                state_next.mode          = fmc_pkg::MODE_SHUTDOWN;
                state_next.timed_out     = 1'b1;
                state_next.refresh_count = '0;
            end else begin
                state_next.refresh_count = state_reg.refresh_count + 32'h1;
            end
        end
        // Read value shows the pin for the force bit
        state_next.rdata = {voltage_mode_pin, state_next.mode,
                            state_next.outer_led_flash_level,
                            state_next.centre_led_flash_level};
        unique case (state_next.mode)
            fmc_pkg::MODE_SHUTDOWN: state_next.op = fmc_pkg::FMC_OP_SHUTDOWN;
            fmc_pkg::MODE_DC_LIGHT: state_next.op = fmc_pkg::FMC_OP_DC_LIGHT;
            fmc_pkg::MODE_DC_FLASH: state_next.op = fmc_pkg::FMC_OP_DC_FLASH;
            fmc_pkg::MODE_VOLTAGE:  state_next.op = fmc_pkg::FMC_OP_VOLTAGE;
        endcase
        state_next.vsrc = state_next.voltage_mode_force
                          || (state_next.mode == fmc_pkg::MODE_VOLTAGE);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '{voltage_mode_force:     fmc_pkg::VOLTAGE_FORCE_RESET,
                           mode:                   fmc_pkg::MODE_RESET,
                           outer_led_flash_level:  fmc_pkg::OUTER_RESET,
                           centre_led_flash_level: fmc_pkg::CENTRE_RESET,
                           rdata:                  fmc_pkg::FLASH_CONFIG_RESET,
                           mirror_write:           1'b0,
                           mirror_value:           fmc_pkg::MODE_RESET,
                           op:                     fmc_pkg::FMC_OP_SHUTDOWN,
                           vsrc:                   1'b0,
                           timed_out:              1'b0,
                           refresh_count:          32'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Flash currents only while the mode permits flash; codes stay held otherwise
    assign flash_ok = (state_reg.op == fmc_pkg::FMC_OP_DC_FLASH);

    fmc_current_lut u_lut (
        .core_clk            (core_clk),
        .resetn              (resetn),
        .enable              (flash_ok),
        .high_current_select (high_current_select),
        .outer_code          (state_reg.outer_led_flash_level),
        .centre_code         (state_reg.centre_led_flash_level),
        .outer_ma            (outer_led_ma),
        .centre_ma           (centre_led_ma)
    );

    assign flash_config_rdata    = state_reg.rdata;
    assign dc_light_mode_write   = state_reg.mirror_write;
    assign dc_light_mode_value   = state_reg.mirror_value;
    assign op_mode               = state_reg.op;
    assign voltage_source_active = state_reg.vsrc;
    assign timeout_shutdown      = state_reg.timed_out;
endmodule // fmc_flash_config
`default_nettype wire

// ==== test/fmc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fmc_host_model (
    input  wire logic       core_clk,
    output logic            reg_write,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_write = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // Each write to offset 0x02 restarts the refresh interval of the mode field
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule // fmc_host_model
`default_nettype wire

// ==== test/fmc_flash_config_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module fmc_flash_config_monitor #(
    parameter longint TIMEOUT_CYCLES = 50
) (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        reg_write,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        voltage_mode_pin,
    input wire logic        high_current_select,
    input wire logic [7:0]  flash_config_rdata,
    input wire logic        dc_light_mode_write,
    input wire logic [1:0]  dc_light_mode_value,
    input wire logic [3:0]  op_mode,
    input wire logic        voltage_source_active,
    input wire logic        timeout_shutdown,
    input wire logic [15:0] outer_led_ma,
    input wire logic [15:0] centre_led_ma
);
    wire logic wr = reg_write && reg_addr == fmc_pkg::FLASH_CONFIG_OFFSET;
    logic [31:0] idle_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            idle_reg <= '0;
        end else begin
            idle_reg <= wr ? '0 : idle_reg + 32'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    mirror_copy_a: assert property (wr |=> dc_light_mode_write &&
        dc_light_mode_value == $past(reg_wdata[6:5])) else $error("mirror copy wrong");
    stray_mirror_a: assert property (!wr |=> !dc_light_mode_write)
        else $error("stray mirror pulse");
    mode_decode_a: assert property (wr |=> op_mode == 4'h1 << $past(reg_wdata[6:5]))
        else $error("bad op mode");
    force_bit_a: assert property (wr |=> voltage_source_active ==
        ($past(reg_wdata[7]) || $past(reg_wdata[6:5]) == 2'h3)) else $error("bad vsrc");
    pin_readback_a: assert property ($past(resetn) |->
        flash_config_rdata[7] == $past(voltage_mode_pin)) else $error("bad pin readback");
    code_hold_a: assert property (wr |=> flash_config_rdata[6:0] == $past(reg_wdata[6:0]))
        else $error("fields not held");
    dark_leds_a: assert property (wr && reg_wdata[6:5] != 2'h2 ##1 !wr |=>
        outer_led_ma == 16'h0 && centre_led_ma == 16'h0) else $error("current outside flash");
    outer_level_a: assert property (wr && reg_wdata[6:5] == 2'h2 ##1 !wr |=> outer_led_ma ==
        ($past(high_current_select) ? fmc_pkg::OUTER_MA_HI[$past(reg_wdata[4:3], 2)]
        : fmc_pkg::OUTER_MA_LO[$past(reg_wdata[4:3], 2)])) else $error("bad outer current");
    centre_level_a: assert property (wr && reg_wdata[6:5] == 2'h2 ##1 !wr |=>
        centre_led_ma == ($past(high_current_select)
        ? fmc_pkg::CENTRE_MA_HI[$past(reg_wdata[2:0], 2)]
        : fmc_pkg::CENTRE_MA_LO[$past(reg_wdata[2:0], 2)])) else $error("bad centre current");
    refresh_timeout_a: assert property ($rose(timeout_shutdown) |->
        idle_reg == 32'(TIMEOUT_CYCLES) && op_mode == 4'h1) else $error("bad timeout");
    cover property (wr && reg_wdata[6:5] == 2'h2);
    cover property ($rose(timeout_shutdown));
    cover property (voltage_mode_pin && voltage_source_active);
endmodule // fmc_flash_config_monitor
bind fmc_flash_config fmc_flash_config_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
    .core_clk(core_clk), .resetn(resetn), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .voltage_mode_pin(voltage_mode_pin),
    .high_current_select(high_current_select), .flash_config_rdata(flash_config_rdata),
    .dc_light_mode_write(dc_light_mode_write), .dc_light_mode_value(dc_light_mode_value),
    .op_mode(op_mode), .voltage_source_active(voltage_source_active),
    .timeout_shutdown(timeout_shutdown), .outer_led_ma(outer_led_ma),
    .centre_led_ma(centre_led_ma));
`default_nettype wire

// ==== test/test_flash_mode_current_register.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_flash_mode_current_register;
    localparam longint TO = 50;
    logic             core_clk = 1'b0, resetn = 1'b0, pin = 1'b0, hcs = 1'b0;
    wire logic        wr, mw, vsrc, tout;
    wire logic [1:0]  mv;
    wire logic [3:0]  opm;
    wire logic [7:0]  addr, wdata, rdata;
    wire logic [15:0] oma, cma;
    int               num_errors = 0, checks_done = 0;
    always #20 core_clk = ~core_clk;
    fmc_host_model u_host (.core_clk(core_clk), .reg_write(wr), .reg_addr(addr),
        .reg_wdata(wdata));
    fmc_flash_config #(.TIMEOUT_CYCLES(TO)) u_dut (.core_clk(core_clk), .resetn(resetn),
        .reg_write(wr), .reg_addr(addr), .reg_wdata(wdata), .voltage_mode_pin(pin),
        .high_current_select(hcs), .flash_config_rdata(rdata), .dc_light_mode_write(mw),
        .dc_light_mode_value(mv), .op_mode(opm), .voltage_source_active(vsrc),
        .timeout_shutdown(tout), .outer_led_ma(oma), .centre_led_ma(cma));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
        u_host.write_reg(a, d);
        @(negedge core_clk);
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wr_chk(8'h02, {1'b0, m[1:0], 5'h0b});
            chk("op mode", 16'h1 << m, {12'h0, opm});
            chk("vsrc", 16'(m == 3), {15'h0, vsrc});
            chk("mirror", {13'h0, 1'b1, m[1:0]}, {13'h0, mw, mv});
            chk("fields", {8'h0, 1'b0, m[1:0], 5'h0b}, {8'h0, rdata});
        end
        wr_chk(8'h03, 8'hff);
        chk("unmapped", 16'h006b, {7'h0, mw, rdata});
    endtask
    task automatic t_force;
        wr_chk(8'h02, 8'h80);
        chk("vsrc forced", 16'h1, {15'h0, vsrc});
        chk("pin low", 16'h0, {15'h0, rdata[7]});
        @(posedge core_clk) pin <= 1'b1;
        wr_chk(8'h02, 8'h00);
        chk("vsrc normal", 16'h0, {15'h0, vsrc});
        chk("pin high", 16'h1, {15'h0, rdata[7]});
        @(posedge core_clk) pin <= 1'b0;
    endtask
    task automatic t_levels;
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk) hcs <= i[3];
            wr_chk(8'h02, {3'h2, i[1:0], i[2:0]});
            @(negedge core_clk);
            chk("outer", i[3] ? fmc_pkg::OUTER_MA_HI[i[1:0]]
                : fmc_pkg::OUTER_MA_LO[i[1:0]], oma);
            chk("centre", i[3] ? fmc_pkg::CENTRE_MA_HI[i[2:0]]
                : fmc_pkg::CENTRE_MA_LO[i[2:0]], cma);
        end
        wr_chk(8'h02, 8'h3f);
        @(negedge core_clk);
        chk("dark", 16'h0, oma | cma);
    endtask
    task automatic t_timeout;
        wr_chk(8'h02, 8'h20);
        repeat (TO - 6) @(posedge core_clk);
        wr_chk(8'h02, 8'h20);
        repeat (TO - 1) @(posedge core_clk);
        @(negedge core_clk);
        chk("refreshed", 16'h0, {15'h0, tout});
        @(negedge core_clk);
        chk("timeout", 16'h0110, {7'h0, tout, opm, 1'b0, rdata[6:5], 1'b0});
        wr_chk(8'h02, 8'h00);
        chk("timeout clear", 16'h0, {15'h0, tout});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        @(negedge core_clk);
        chk("reset", 16'h0103, {4'h0, opm, rdata});
        t_modes();
        t_force();
        t_levels();
        t_timeout();
        tally_and_finish();
    end
endmodule // test_flash_mode_current_register
`default_nettype wire
